// ==== logic/bsa_core.sv ====
// Battery alarm flags, status word, error codes and alert sender
`include "bsa_consts.svh"
`default_nettype none
// Summary of operation
// - Words 16 bits, bytes and chars 8
// - Boolean word: zero false, nonzero true
// - Block count byte excludes itself, max 31
// - Strings use same count-prefixed 32-byte block
// - Charge-excess flag tracks over-charging
// - Stop-charging flag while parameter out of range
// - Heat-limit flag while temperature too high
// - Stop-draining flag until charge safe again
// - Low-capacity flag versus capacity threshold
// - Low-runtime flag versus runtime threshold
// - Calibrated flag set, cleared on data loss
// - Not-charging flag follows charging detection
// - Charge-complete flag until charge accepted again
// - Depleted flag held until fill reaches 20%
// - Code 0x0000 success, 0x0001 busy
// - Code 0x0002 reserved or unimplemented optional
// - Code 0x0003 defined but unsupported command
// - Code 0x0004 write to read-only command
// - Code 0x0005 overflow or underflow
// - Code 0x0006 block size mismatch on write
// - Code 0x0007 for any other error
// - Every error also withholds acknowledge
// - Capacity/runtime alerts host only, others both
// - Alert status low nibble forced to ones
// - Alert: target, own address, 16-bit status
module bsa_core #(
  parameter logic [6:0] HOST_ADDR = 7'h01,
  parameter logic [6:0] CHGR_ADDR = 7'h02,
  parameter logic [6:0] BATT_ADDR = 7'h03,
  parameter logic [35:0] SUPPORTED = 36'hf_ffff_ffff,
  parameter logic [4:0] OPT_IMPL = 5'h00
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire bsa_pkg::bsa_meas_t meas_in,
  input wire bsa_pkg::bsa_cmd_t cmd_in,
  output logic [15:0] status_out,
  output logic [15:0] err_code_out,
  output logic cmd_done_out,
  output logic cmd_nack_out,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic alert_busy_out
);
  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (HOST_ADDR == BATT_ADDR || CHGR_ADDR == BATT_ADDR) begin : g_chk
    $error("bsa_core: own address collides with a target address");
  end

  bsa_pkg::bsa_state_s_t s_r;
  bsa_pkg::bsa_state_s_t s_nxt;
  logic scl_fall;
  logic scl_rise;
  logic [7:0] new_alarm;
  logic [15:0] err;
  logic is_reserved;
  logic is_opt;
  logic is_unimpl;
  logic is_wprot;
  logic is_blk_cmd;
  logic is_len_bad;

  // ****************************************************************
  // Alert frame bit source
  // ****************************************************************
  // MSB first; write bit is zero in both address bytes
  function automatic logic frame_bit(input logic [1:0] byte_i,
                                     input logic [3:0] bit_i,
                                     input logic to_chgr,
                                     input logic [15:0] word);
    logic [7:0] b;
    b = 8'h00;
    case (byte_i)
      2'h0: b = {to_chgr ? CHGR_ADDR : HOST_ADDR, 1'b0};
      2'h1: b = {BATT_ADDR, 1'b0};
      2'h2: b = word[7:0];
      default: b = word[15:8];
    endcase
    frame_bit = b[3'(4'h7 - bit_i)];
  endfunction

  // ****************************************************************
  // Command code decode
  // ****************************************************************
  // Optional vendor codes: index 0 is 0x2f, 1..4 are 0x3c..0x3f
  always_comb begin
    is_opt = (cmd_in.code == `BSA_CODE_OPT5) ||
             ((cmd_in.code & 8'hfc) == `BSA_CODE_OPT_LO);
    is_reserved = ((cmd_in.code & `BSA_CODE_HI_MASK) != 8'h00) ||
                  (cmd_in.code >= `BSA_CODE_RSV_LO &&
                   cmd_in.code <= `BSA_CODE_RSV_HI) ||
                  (!is_opt && cmd_in.code > `BSA_CODE_STD_LAST);
    if (cmd_in.code == `BSA_CODE_OPT5) begin
      is_reserved = !OPT_IMPL[0];
    end else if (is_opt) begin
      is_reserved = !OPT_IMPL[3'(cmd_in.code[1:0]) + 3'h1];
    end
    is_unimpl = !is_opt && !is_reserved &&
                !SUPPORTED[cmd_in.code[5:0]];
    is_wprot = cmd_in.write && !is_opt &&
               cmd_in.code > `BSA_CODE_WR_LAST;
    is_blk_cmd = cmd_in.code == `BSA_CODE_OPT5 ||
                 (cmd_in.code >= `BSA_CODE_BLK_FIRST &&
                  cmd_in.code <= `BSA_CODE_STD_LAST);
    // Count byte excludes itself, so the payload is at most 31
    is_len_bad = cmd_in.write && ((is_blk_cmd != cmd_in.block) ||
                 (cmd_in.block && cmd_in.count >= `BSA_BLOCK_MAX));
    // Busy first: nothing else is known while busy
    if (cmd_in.busy) begin
      err = `BSA_ERR_BUSY;
    end else if (is_reserved) begin
      err = `BSA_ERR_RESERVED;
    end else if (is_unimpl) begin
      err = `BSA_ERR_UNIMPL;
    end else if (is_wprot) begin
      err = `BSA_ERR_WPROT;
    end else if (is_len_bad) begin
      err = `BSA_ERR_LEN;
    end else if (cmd_in.overflow) begin
      err = `BSA_ERR_OVF;
    end else if (cmd_in.unknown) begin
      err = `BSA_ERR_UNCLASS;
    end else begin
      err = `BSA_ERR_OK;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.nack = 1'b0;
    s_nxt.rdata = 16'h0000;
    // Link pins: two flops before anything looks at them
    s_nxt.scl_meta = scl_in;
    s_nxt.scl_sync = s_r.scl_meta;
    s_nxt.scl_prev = s_r.scl_sync;
    s_nxt.sda_meta = sda_in;
    s_nxt.sda_sync = s_r.sda_meta;
    scl_fall = s_r.scl_prev && !s_r.scl_sync;
    scl_rise = !s_r.scl_prev && s_r.scl_sync;

    // Register writes; boolean words test the whole word
    if (reg_wr_in) begin
      case (reg_addr_in)
        `BSA_OFF_CAP_THR: s_nxt.cap_thr = reg_wdata_in;
        `BSA_OFF_RUN_THR: s_nxt.run_thr = reg_wdata_in;
        `BSA_OFF_ALERT_EN: s_nxt.alert_en = |reg_wdata_in;
        default: s_nxt.alert_en = s_r.alert_en;
      endcase
    end
    // Register reads, answered the next cycle; holes read zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        `BSA_OFF_STATUS: s_nxt.rdata = s_r.status;
        `BSA_OFF_CAP_THR: s_nxt.rdata = s_r.cap_thr;
        `BSA_OFF_RUN_THR: s_nxt.rdata = s_r.run_thr;
        `BSA_OFF_ALERT_EN: s_nxt.rdata = {15'h0000, s_r.alert_en};
        `BSA_OFF_ERR: s_nxt.rdata = s_r.err_code;
        `BSA_OFF_CAL: s_nxt.rdata = {15'h0000, s_r.status[`BSA_BIT_CAL]};
        default: s_nxt.rdata = 16'h0000;
      endcase
    end

    // Flags follow the gauge on each update; only the calibrated flag also changes, on a write
    if (meas_in.update) begin
      s_nxt.status[`BSA_BIT_OVERCHG] = meas_in.overcharge;
      s_nxt.status[`BSA_BIT_STOPCHG] = meas_in.param_bad;
      s_nxt.status[`BSA_BIT_HEAT] = meas_in.over_temp;
      if (meas_in.depl_det) begin
        s_nxt.status[`BSA_BIT_STOPDRN] = 1'b1;
      end else if (meas_in.soc_safe) begin
        s_nxt.status[`BSA_BIT_STOPDRN] = 1'b0;
      end
      // Covers both lowering the threshold and charging
      s_nxt.status[`BSA_BIT_LOWCAP] =
        meas_in.capacity_left < s_r.cap_thr;
      if (meas_in.runtime_at_rate < s_r.run_thr) begin
        s_nxt.status[`BSA_BIT_LOWRUN] = 1'b1;
      end else if (meas_in.avg_runtime_estimate >= s_r.run_thr) begin
        s_nxt.status[`BSA_BIT_LOWRUN] = 1'b0;
      end
      if (meas_in.cal_lost) begin
        s_nxt.status[`BSA_BIT_CAL] = 1'b0;
      end
      s_nxt.status[`BSA_BIT_NOTCHG] = !meas_in.charging;
      if (meas_in.charge_term) begin
        s_nxt.status[`BSA_BIT_FULL] = 1'b1;
      end else if (meas_in.can_accept) begin
        s_nxt.status[`BSA_BIT_FULL] = 1'b0;
      end
      if (meas_in.depl_det) begin
        s_nxt.status[`BSA_BIT_DEPL] = 1'b1;
      end else if (meas_in.relative_fill_percent >= `BSA_DEPL_CLR_PCT) begin
        s_nxt.status[`BSA_BIT_DEPL] = 1'b0;
      end
    end
    // Factory calibration mark; set wins over a loss seen now
    if (reg_wr_in && reg_addr_in == `BSA_OFF_CAL && |reg_wdata_in) begin
      s_nxt.status[`BSA_BIT_CAL] = 1'b1;
    end
    s_nxt.status[13] = 1'b0;
    s_nxt.status[10] = 1'b0;

    // Transaction result: code, nack pulse and status nibble
    if (cmd_in.valid) begin
      s_nxt.err_code = err;
      s_nxt.status[3:0] = err[3:0];
      s_nxt.done = 1'b1;
      s_nxt.nack = err != `BSA_ERR_OK;
    end

    // Alert sender: bits change only after the clock falls
    case (s_r.st)
      bsa_pkg::BSA_IDLE: begin
        if ((s_r.pend_host || s_r.pend_chgr) && s_r.scl_sync &&
            s_r.sda_sync) begin
          s_nxt.to_chgr = !s_r.pend_host;
          s_nxt.word = {s_r.status[15:4], `BSA_ALERT_NIBBLE};
          s_nxt.sda_oe = 1'b1;
          s_nxt.abort = 1'b0;
          s_nxt.st = bsa_pkg::BSA_START;
          // Host frame goes first; the charger's waits for the next one
          s_nxt.pend_chgr = s_r.pend_chgr && s_r.pend_host;
          s_nxt.pend_host = 1'b0;
        end
      end
      bsa_pkg::BSA_START: begin
        if (scl_fall) begin
          s_nxt.bit_cnt = 4'h0;
          s_nxt.byte_cnt = 2'h0;
          s_nxt.sda_oe = !frame_bit(2'h0, 4'h0, s_r.to_chgr, s_r.word);
          s_nxt.st = bsa_pkg::BSA_SHIFT;
        end
      end
      bsa_pkg::BSA_SHIFT: begin
        // A missing acknowledge ends the frame early
        if (scl_rise && s_r.bit_cnt == `BSA_ALERT_LAST_BIT &&
            s_r.sda_sync) begin
          s_nxt.abort = 1'b1;
        end
        if (scl_fall) begin
          if (s_r.bit_cnt == `BSA_ALERT_LAST_BIT) begin
            if (s_r.byte_cnt == 2'h3 || s_r.abort) begin
              s_nxt.sda_oe = 1'b1;
              s_nxt.st = bsa_pkg::BSA_STOP;
            end else begin
              s_nxt.byte_cnt = s_r.byte_cnt + 2'h1;
              s_nxt.bit_cnt = 4'h0;
              s_nxt.sda_oe = !frame_bit(s_r.byte_cnt + 2'h1, 4'h0,
                                        s_r.to_chgr, s_r.word);
            end
          end else begin
            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
            // Release the line for the receiver's acknowledge
            if (s_r.bit_cnt + 4'h1 == `BSA_ALERT_LAST_BIT) begin
              s_nxt.sda_oe = 1'b0;
            end else begin
              s_nxt.sda_oe = !frame_bit(s_r.byte_cnt, s_r.bit_cnt + 4'h1,
                                        s_r.to_chgr, s_r.word);
            end
          end
        end
      end
      bsa_pkg::BSA_STOP: begin
        // Data rising while the clock is high ends the frame
        if (scl_rise) begin
          s_nxt.sda_oe = 1'b0;
          s_nxt.st = bsa_pkg::BSA_IDLE;
        end
      end
      default: begin
        s_nxt.sda_oe = 1'b0;
        s_nxt.st = bsa_pkg::BSA_IDLE;
      end
    endcase
    s_nxt.busy = s_nxt.st != bsa_pkg::BSA_IDLE;

    // Newly raised alarms queue alerts; set wins over taking one
    new_alarm = s_nxt.status[15:8] & ~s_r.status[15:8];
    if (s_r.alert_en) begin
      s_nxt.pend_host = s_nxt.pend_host || (|new_alarm);
      s_nxt.pend_chgr = s_nxt.pend_chgr ||
        (|(new_alarm & ~`BSA_HOST_ONLY_MASK));
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r <= '0;
      s_r.cap_thr <= `BSA_CAP_THR_RST;
      s_r.run_thr <= `BSA_RUN_THR_RST;
      s_r.st <= bsa_pkg::BSA_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_out = s_r.rdata;
  assign status_out = s_r.status;
  assign err_code_out = s_r.err_code;
  assign cmd_done_out = s_r.done;
  assign cmd_nack_out = s_r.nack;
  assign sda_out = s_r.sda_o;
  assign sda_oe_out = s_r.sda_oe;
  assign alert_busy_out = s_r.busy;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  property p_busy_code;
    cmd_in.valid && cmd_in.busy |=> err_code_out == 16'h0001 &&
      cmd_nack_out && cmd_done_out;
  endproperty
  a_busy_code: assert property (p_busy_code)
    else $error("busy command did not give code 1");
  property p_reserved_code;
    cmd_in.valid && !cmd_in.busy && cmd_in.code[7:6] != 2'b00
      |=> err_code_out == 16'h0002;
  endproperty
  a_reserved_code: assert property (p_reserved_code)
    else $error("high command code not reported reserved");
  property p_wprot_code;
    cmd_in.valid && !cmd_in.busy && cmd_in.write &&
      cmd_in.code == 8'h09 && SUPPORTED[9] |=> err_code_out == 16'h0004;
  endproperty
  a_wprot_code: assert property (p_wprot_code)
    else $error("write to read-only code not refused");
  property p_nack_on_error;
    cmd_done_out |-> cmd_nack_out == (err_code_out != 16'h0000);
  endproperty
  a_nack_on_error: assert property (p_nack_on_error)
    else $error("acknowledge does not match error code");
  property p_status_err;
    cmd_done_out |-> status_out[3:0] == err_code_out[3:0] ##1
      (cmd_done_out || status_out[3:0] == $past(err_code_out[3:0]));
  endproperty
  a_status_err: assert property (p_status_err)
    else $error("status nibble lost the last error code");
  property p_heat;
    meas_in.update |=> status_out[12] == $past(meas_in.over_temp);
  endproperty
  a_heat: assert property (p_heat)
    else $error("heat flag does not follow temperature");
  property p_depl_clear;
    meas_in.update && !meas_in.depl_det &&
      meas_in.relative_fill_percent >= 8'h14 |=> !status_out[4];
  endproperty
  a_depl_clear: assert property (p_depl_clear)
    else $error("depleted flag held above 20 percent");
  property p_flags_hold;
    !meas_in.update && !reg_wr_in |=> status_out[15:4] ==
      $past(status_out[15:4]);
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags changed without an update");
  property p_alert_nibble;
    s_r.st != bsa_pkg::BSA_IDLE |-> s_r.word[3:0] == 4'hf;
  endproperty
  a_alert_nibble: assert property (p_alert_nibble)
    else $error("alert status low nibble not all ones");
  property p_start_cond;
    s_r.st == bsa_pkg::BSA_IDLE ##1 s_r.st == bsa_pkg::BSA_START
      |-> sda_oe_out && s_r.scl_prev;
  endproperty
  a_start_cond: assert property (p_start_cond)
    else $error("alert started without clock high");
  c_alert_sent: cover property (s_r.st == bsa_pkg::BSA_STOP ##1
    s_r.st == bsa_pkg::BSA_IDLE);
  c_busy_err: cover property (cmd_done_out && err_code_out == 16'h0001);
  c_depleted: cover property (!status_out[4] ##1 status_out[4]);
  c_charger_alert: cover property (s_r.busy && s_r.to_chgr);
endmodule
`default_nettype wire

// ==== logic/bsa_consts.svh ====
// Offsets, field positions, reset values and codes of the alarm block
`ifndef BSA_CONSTS_SVH
`define BSA_CONSTS_SVH
`default_nettype none
// ****************************************************************
// Data encodings
// ****************************************************************
`define BSA_WORD_W 16
`define BSA_BYTE_W 8
`define BSA_BLOCK_MAX 8'h20
// ****************************************************************
// Register offsets and reset values
// ****************************************************************
`define BSA_OFF_STATUS 8'h00
`define BSA_OFF_CAP_THR 8'h04
`define BSA_OFF_RUN_THR 8'h08
`define BSA_OFF_ALERT_EN 8'h0c
`define BSA_OFF_ERR 8'h10
`define BSA_OFF_CAL 8'h14
`define BSA_CAP_THR_RST 16'h0000
`define BSA_RUN_THR_RST 16'h0000
// ****************************************************************
// Status word fields
// ****************************************************************
`define BSA_BIT_OVERCHG 15
`define BSA_BIT_STOPCHG 14
`define BSA_BIT_HEAT 12
`define BSA_BIT_STOPDRN 11
`define BSA_BIT_LOWCAP 9
`define BSA_BIT_LOWRUN 8
`define BSA_BIT_CAL 7
`define BSA_BIT_NOTCHG 6
`define BSA_BIT_FULL 5
`define BSA_BIT_DEPL 4
`define BSA_HOST_ONLY_MASK 8'h03
`define BSA_ALERT_NIBBLE 4'hf
`define BSA_DEPL_CLR_PCT 8'h14
// ****************************************************************
// Error codes and command code ranges
// ****************************************************************
`define BSA_ERR_OK 16'h0000
`define BSA_ERR_BUSY 16'h0001
`define BSA_ERR_RESERVED 16'h0002
`define BSA_ERR_UNIMPL 16'h0003
`define BSA_ERR_WPROT 16'h0004
`define BSA_ERR_OVF 16'h0005
`define BSA_ERR_LEN 16'h0006
`define BSA_ERR_UNCLASS 16'h0007
`define BSA_CODE_HI_MASK 8'hc0
`define BSA_CODE_WR_LAST 8'h04
`define BSA_CODE_STD_LAST 8'h23
`define BSA_CODE_RSV_LO 8'h1d
`define BSA_CODE_RSV_HI 8'h1f
`define BSA_CODE_BLK_FIRST 8'h20
`define BSA_CODE_OPT5 8'h2f
`define BSA_CODE_OPT_LO 8'h3c
`define BSA_ALERT_LAST_BIT 4'h8
`default_nettype wire
`endif

// ==== logic/bsa_pkg.sv ====
// Types shared by the battery status and alarm block
`default_nettype none
package bsa_pkg;
  // Alert sender states, one-hot
  typedef enum logic [3:0] {
    BSA_IDLE = 4'h1,
    BSA_START = 4'h2,
    BSA_SHIFT = 4'h4,
    BSA_STOP = 4'h8
  } bsa_state_t;

  // Measurement update from the gauge, same clock
  typedef struct packed {
    logic update;
    logic overcharge;
    logic param_bad;
    logic over_temp;
    logic depl_det;
    logic soc_safe;
    logic cal_lost;
    logic charging;
    logic charge_term;
    logic can_accept;
    logic [15:0] capacity_left;
    logic [15:0] runtime_at_rate;
    logic [15:0] avg_runtime_estimate;
    logic [7:0] relative_fill_percent;
  } bsa_meas_t;

  // One decoded command transaction from the bus slave
  typedef struct packed {
    logic valid;
    logic write;
    logic block;
    logic busy;
    logic overflow;
    logic unknown;
    logic [7:0] code;
    logic [7:0] count;
  } bsa_cmd_t;

  // Whole state of the block
  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic [15:0] cap_thr;
    logic [15:0] run_thr;
    logic alert_en;
    logic [15:0] status;
    logic [15:0] err_code;
    logic done;
    logic nack;
    logic [15:0] rdata;
    logic pend_host;
    logic pend_chgr;
    bsa_state_t st;
    logic to_chgr;
    logic [3:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [15:0] word;
    logic abort;
    logic sda_oe;
    logic sda_o;
    logic busy;
  } bsa_state_s_t;
endpackage
`default_nettype wire

// ==== verif/bsa_host_model.sv ====
// Host-side bus model: clocks alert frames, acknowledges, captures bytes
`default_nettype none
module bsa_host_model (
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ack_low = 1'b0;
  logic go = 1'b0;
  logic stop_seen = 1'b0;
  logic [7:0] sh = 8'h00;
  int k;
  logic [7:0] bytes_q[$];
  // Open drain with pull-up: low while either party pulls
  assign sda_out = ~(sda_oe_in | ack_low);
  // Start and stop found by the data line moving while clock is high
  always @(negedge sda_out) if (scl_out) go = 1'b1;
  always @(posedge sda_out) if (scl_out) stop_seen = 1'b1;
  // ******
  // Frame clocking, only while a frame is open
  // ******
  initial begin
    scl_out = 1'b1;
    forever begin
      wait (go);
      go = 1'b0;
      stop_seen = 1'b0;
      k = 0;
      #100;
      while (!stop_seen) begin
        scl_out = 1'b0;
        ack_low = (k % 9 == 8) && (k < 36);
        #100;
        scl_out = 1'b1;
        if (k % 9 != 8) sh = {sh[6:0], sda_out};
        else if (k < 36) bytes_q.push_back(sh);
        k++;
        #100;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/bsa_core_tb.sv ====
// Self-checking bench of the battery status and alarm block
`default_nettype none
module bsa_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out, status_out, err_code_out;
  logic cmd_done_out, cmd_nack_out, sda_oe_out, alert_busy_out;
  wire logic scl, sda;
  bsa_pkg::bsa_meas_t meas_in = '0;
  bsa_pkg::bsa_cmd_t cmd_in = '0;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 clock_in = ~clock_in;
  // Code 0x05 left unsupported, first optional code implemented
  bsa_core #(.SUPPORTED(36'hf_ffff_ffdf), .OPT_IMPL(5'h01)) bsa_core_i (
    .clock_in(clock_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .meas_in(meas_in), .cmd_in(cmd_in),
    .status_out(status_out), .err_code_out(err_code_out),
    .cmd_done_out(cmd_done_out), .cmd_nack_out(cmd_nack_out),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe_out),
    .alert_busy_out(alert_busy_out));
  bsa_host_model bsa_host_model_i (.sda_oe_in(sda_oe_out),
    .scl_out(scl), .sda_out(sda));
  // ******
  // Access tasks and comparison
  // ******
  task automatic chk(input string w, input logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 chk("read data", e, reg_rdata_out);
  endtask
  // Qualifiers are write, block, busy, overflow, unknown
  task automatic cmd(input logic [7:0] c, input logic [4:0] q,
                     input logic [7:0] n, input logic [15:0] e);
    @(posedge clock_in);
    cmd_in <= {1'b1, q, c, n};
    @(posedge clock_in);
    cmd_in.valid <= 1'b0;
    #1 chk("done", 16'h0001, {15'h0, cmd_done_out});
    chk("nack", {15'h0, e != 16'h0}, {15'h0, cmd_nack_out});
    chk("error code", e, err_code_out);
    chk("status nibble", {12'h0, e[3:0]}, {12'h0, status_out[3:0]});
  endtask
  // Flags: overchg, param, temp, depl, safe, cal_lost, chg, term, accept
  task automatic meas(input logic [8:0] f, input logic [15:0] run, avg,
                      cap, input logic [7:0] pct, input logic [15:0] e);
    @(posedge clock_in);
    meas_in <= {1'b1, f, cap, run, avg, pct};
    @(posedge clock_in);
    meas_in.update <= 1'b0;
    #1 chk("status flags", e, status_out & 16'hfff0);
  endtask
  task automatic frame(input int b, input logic [7:0] t, hi);
    logic [7:0] e[4];
    e = '{t, 8'h06, 8'h0f, hi};
    for (int i = 0; i < 800 && bsa_host_model_i.bytes_q.size() < b + 4; i++)
      @(posedge clock_in);
    for (int i = 0; i < 4; i++)
      chk("alert byte", {8'h0, e[i]}, {8'h0, bsa_host_model_i.bytes_q[b + i]});
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard: the whole run needs under two thousand cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("unexpected cycle count: expected below 20000, seen 20000");
      results();
    end
  end
  // ******
  // Test sequence
  // ******
  initial begin
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h08, 16'h0000);
    wr(8'h40, 16'h5a5a);
    rd(8'h40, 16'h0000);
    wr(8'h04, 16'h0100);
    wr(8'h08, 16'h0020);
    rd(8'h04, 16'h0100);
    rd(8'h08, 16'h0020);
    $display("test registers done");
    wr(8'h0c, 16'h0001);
    meas(9'h044, 16'hffff, 16'hffff, 16'hffff, 8'h64, 16'h1000);
    frame(0, 8'h02, 8'h10);
    chk("alert busy", 16'h0001, {15'h0, alert_busy_out});
    frame(4, 8'h04, 8'h10);
    meas(9'h044, 16'hffff, 16'hffff, 16'h00ff, 8'h64, 16'h1200);
    frame(8, 8'h02, 8'h12);
    repeat (700) @(posedge clock_in);
    chk("alert busy", 16'h0000, {15'h0, alert_busy_out});
    chk("alert count", 16'd12, 16'(bsa_host_model_i.bytes_q.size()));
    wr(8'h0c, 16'h0000);
    $display("test alerts done");
    meas(9'h180, 16'hffff, 16'hffff, 16'hffff, 8'h64, 16'hc040);
    meas(9'h020, 16'hffff, 16'hffff, 16'hffff, 8'h13, 16'h0850);
    meas(9'h010, 16'hffff, 16'hffff, 16'hffff, 8'h13, 16'h0050);
    meas(9'h000, 16'hffff, 16'hffff, 16'hffff, 8'h14, 16'h0040);
    meas(9'h006, 16'hffff, 16'hffff, 16'hffff, 8'h64, 16'h0020);
    meas(9'h005, 16'hffff, 16'hffff, 16'hffff, 8'h64, 16'h0000);
    meas(9'h004, 16'h001f, 16'h0010, 16'hffff, 8'h64, 16'h0100);
    meas(9'h004, 16'hffff, 16'h001f, 16'hffff, 8'h64, 16'h0100);
    meas(9'h004, 16'hffff, 16'h0020, 16'hffff, 8'h64, 16'h0000);
    meas(9'h004, 16'hffff, 16'hffff, 16'h0100, 8'h64, 16'h0000);
    wr(8'h14, 16'h0001);
    rd(8'h14, 16'h0001);
    meas(9'h004, 16'hffff, 16'hffff, 16'hffff, 8'h64, 16'h0080);
    meas(9'h00c, 16'hffff, 16'hffff, 16'hffff, 8'h64, 16'h0000);
    chk("alert count", 16'd12, 16'(bsa_host_model_i.bytes_q.size()));
    $display("test flags done");
    cmd(8'h09, 5'h00, 8'h00, 16'h0000);
    cmd(8'h09, 5'h04, 8'h00, 16'h0001);
    cmd(8'h1d, 5'h00, 8'h00, 16'h0002);
    cmd(8'h3c, 5'h10, 8'h00, 16'h0002);
    cmd(8'h41, 5'h00, 8'h00, 16'h0002);
    cmd(8'h05, 5'h00, 8'h00, 16'h0003);
    cmd(8'h09, 5'h10, 8'h00, 16'h0004);
    cmd(8'h01, 5'h10, 8'h00, 16'h0000);
    cmd(8'h03, 5'h18, 8'h02, 16'h0006);
    cmd(8'h2f, 5'h18, 8'h20, 16'h0006);
    cmd(8'h2f, 5'h18, 8'h1f, 16'h0000);
    cmd(8'h09, 5'h02, 8'h00, 16'h0005);
    cmd(8'h09, 5'h01, 8'h00, 16'h0007);
    rd(8'h10, 16'h0007);
    rd(8'h00, 16'h0007);
    $display("test commands done");
    results();
  end
endmodule
`default_nettype wire
